// ### sea_pkg.sv
// Overview of operation
// - fields: deref, index, function, page, offset
// - page bit picks current sector (counter-relative in relative modes) or zero
// - basic format zero-extends the nine-bit offset
// - small mode preindexes; larger modes postindex except in basic format
// - sector-relative joins counter sector and offset
// - clear top two, one or no address bits (small, large, full mode)
// - relative offset is signed, added to counter
// - both high offset bits one means code
// - indirect address 14, 15 or 16 bits
// - full mode allows one indirection level only
// - index added, then truncated to mode width
// - sector is 512 words, numbered from bit nine up
package sea_pkg;

    typedef enum logic [1:0] {
        SEA_SMALL_SECTORED = 2'b00,
        SEA_LARGE_SECTORED = 2'b01,
        SEA_RELATIVE_LARGE = 2'b10,
        SEA_RELATIVE_FULL = 2'b11
    } sea_mode_t;

    typedef enum logic [0:0] {
        SEA_ST_IDLE = 1'b0,
        SEA_ST_FETCH = 1'b1
    } sea_state_t;

    localparam int SEA_WORD_W = 16;
    localparam int SEA_OFFSET_W = 9;
    localparam int SEA_FUNC_W = 4;
    localparam int SEA_SECTOR_W = SEA_WORD_W - SEA_OFFSET_W;

    localparam int SEA_DEREF_POS = 15;
    localparam int SEA_OFFADD_POS = 14;
    localparam int SEA_FUNC_LSB = 10;
    localparam int SEA_PAGE_POS = 9;
    localparam int SEA_OFFSET_LSB = 0;
    localparam int SEA_CHAIN_POS = 15;

    localparam logic [15:0] SEA_MASK_SMALL = 16'h3FFF;
    localparam logic [15:0] SEA_MASK_LARGE = 16'h7FFF;
    localparam logic [15:0] SEA_MASK_FULL = 16'hFFFF;
    localparam logic [15:0] SEA_ZERO_WORD = 16'h0000;

    localparam logic [1:0] SEA_CODE_PREFIX = 2'h3;
    localparam logic signed [9:0] SEA_REL_MIN = -10'sd240;

    function automatic logic [15:0] sea_mask(input sea_mode_t m);
        logic [15:0] r;
        r = SEA_MASK_FULL;
        unique case (m)
            SEA_SMALL_SECTORED: r = SEA_MASK_SMALL;
            SEA_LARGE_SECTORED: r = SEA_MASK_LARGE;
            SEA_RELATIVE_LARGE: r = SEA_MASK_LARGE;
            SEA_RELATIVE_FULL: r = SEA_MASK_FULL;
        endcase
        return r;
    endfunction

    function automatic logic sea_is_relative(input sea_mode_t m);
        return m == SEA_RELATIVE_LARGE || m == SEA_RELATIVE_FULL;
    endfunction

endpackage

// ### sea_field_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sea_field_decode
    import sea_pkg::*;
(
    // instruction word
    input wire logic [15:0] instr,
    // decoded fields
    output logic deref_flag,
    output logic offset_add_flag,
    output logic [3:0] function_code,
    output logic page_bit,
    output logic [8:0] local_offset
);
    // bit 1 of the word is the msb
    assign deref_flag = instr[SEA_DEREF_POS];
    assign offset_add_flag = instr[SEA_OFFADD_POS];
    assign function_code = instr[SEA_FUNC_LSB +: SEA_FUNC_W];
    assign page_bit = instr[SEA_PAGE_POS];
    assign local_offset = instr[SEA_OFFSET_LSB +: SEA_OFFSET_W];
endmodule // sea_field_decode
`default_nettype wire

// ### sea_direct_form.sv
`timescale 1ns/1ps
`default_nettype none
module sea_direct_form
    import sea_pkg::*;
(
    // mode and fields
    input wire sea_mode_t mode,
    input wire logic page_bit,
    input wire logic [8:0] local_offset,
    input wire logic [15:0] next_instr_count,
    // formed address before indexing
    output logic [15:0] base_addr,
    output logic pre_index,
    output logic ext_code
);
    logic signed [9:0] sdisp;
    logic [15:0] sext;
    logic [15:0] sector_addr;

    assign sdisp = {local_offset[8], local_offset};
    assign sext = {{7{local_offset[8]}}, local_offset};
    // counter supplies the sector above the 512-word location
    assign sector_addr = {next_instr_count[15:SEA_OFFSET_W], local_offset};

    always_comb begin
        base_addr = SEA_ZERO_WORD;
        ext_code = 1'b0;
        if (!page_bit) begin
            base_addr = {{SEA_SECTOR_W{1'b0}}, local_offset};
        end else if (sea_is_relative(mode)) begin
            if (local_offset[8:7] == SEA_CODE_PREFIX) begin
                ext_code = 1'b1;
            end else if (sdisp < SEA_REL_MIN) begin
                ext_code = 1'b1;
            end else begin
                base_addr = 16'(next_instr_count + sext);
            end
        end else begin
            base_addr = sector_addr;
        end
    end

    // small mode indexes first; larger modes only in basic format
    assign pre_index = (mode == SEA_SMALL_SECTORED) || !page_bit;
endmodule // sea_direct_form
`default_nettype wire

// ### sea_effective_address.sv
`timescale 1ns/1ps
`default_nettype none
module sea_effective_address
    import sea_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request from instruction fetch
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] next_instr_count,
    input wire logic [15:0] index_reg,
    input wire sea_mode_t mode,
    output logic busy,
    // indirect word reads
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // result
    output logic ea_valid,
    output logic [15:0] ea,
    output logic [3:0] ea_function,
    output logic ext_valid,
    output logic [8:0] ext_field,
    output logic [3:0] indirect_levels
);
    logic deref_flag;
    logic offset_add_flag;
    logic [3:0] function_code;
    logic page_bit;
    logic [8:0] local_offset;
    logic [15:0] base_addr;
    logic pre_index;
    logic ext_code;

    sea_field_decode u_decode (
        .instr(instr),
        .deref_flag(deref_flag),
        .offset_add_flag(offset_add_flag),
        .function_code(function_code),
        .page_bit(page_bit),
        .local_offset(local_offset)
    );

    sea_direct_form u_form (
        .mode(mode),
        .page_bit(page_bit),
        .local_offset(local_offset),
        .next_instr_count(next_instr_count),
        .base_addr(base_addr),
        .pre_index(pre_index),
        .ext_code(ext_code)
    );

    // working state
    sea_state_t state;
    sea_state_t next_state;
    sea_mode_t cur_mode;
    sea_mode_t next_cur_mode;
    logic post_add;
    logic next_post_add;
    logic [15:0] held_index;
    logic [15:0] next_held_index;
    logic [15:0] mem_addr_q;
    logic [15:0] next_mem_addr_q;
    // result registers
    logic ea_valid_q;
    logic next_ea_valid_q;
    logic [15:0] ea_q;
    logic [15:0] next_ea_q;
    logic [3:0] func_q;
    logic [3:0] next_func_q;
    logic ext_valid_q;
    logic next_ext_valid_q;
    logic [8:0] ext_q;
    logic [8:0] next_ext_q;
    logic [3:0] levels_q;
    logic [3:0] next_levels_q;

    logic [15:0] mask_req;
    logic [15:0] mask_cur;
    logic [15:0] first_addr;
    logic add_now;
    logic [15:0] ptr;
    logic chain;

    assign mask_req = sea_mask(mode);
    assign mask_cur = sea_mask(cur_mode);

    // index goes in before any indirection when not postindexing
    assign add_now = offset_add_flag && (!deref_flag || pre_index);
    // sum then truncate; upper bits cleared to the mode width
    assign first_addr = 16'(base_addr + (add_now ? index_reg : SEA_ZERO_WORD))
        & mask_req;

    // indirect word gives an address of the mode width
    assign ptr = mem_rdata & mask_cur;
    // full mode: the whole word is address, no further level
    assign chain = (cur_mode != SEA_RELATIVE_FULL)
        && mem_rdata[SEA_CHAIN_POS];

    always_comb begin
        next_state = state;
        next_cur_mode = cur_mode;
        next_post_add = post_add;
        next_held_index = held_index;
        next_mem_addr_q = mem_addr_q;
        next_ea_valid_q = 1'b0;
        next_ea_q = ea_q;
        next_func_q = func_q;
        next_ext_valid_q = 1'b0;
        next_ext_q = ext_q;
        next_levels_q = levels_q;
        unique case (state)
            SEA_ST_IDLE: begin
                if (start) begin
                    next_func_q = function_code;
                    next_cur_mode = mode;
                    next_held_index = index_reg;
                    next_levels_q = 4'h0;
                    if (ext_code) begin
                        next_ext_valid_q = 1'b1;
                        next_ext_q = local_offset;
                    end else if (deref_flag) begin
                        next_state = SEA_ST_FETCH;
                        next_mem_addr_q = first_addr;
                        next_post_add = offset_add_flag && !pre_index;
                    end else begin
                        next_ea_valid_q = 1'b1;
                        next_ea_q = first_addr;
                    end
                end
            end
            SEA_ST_FETCH: begin
                if (mem_ack) begin
                    next_levels_q = 4'(levels_q + 4'h1);
                    if (chain) begin
                        next_mem_addr_q = ptr;
                    end else begin
                        next_state = SEA_ST_IDLE;
                        next_ea_valid_q = 1'b1;
                        next_ea_q = 16'(ptr + (post_add ? held_index
                            : SEA_ZERO_WORD)) & mask_cur;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEA_ST_IDLE;
            cur_mode <= SEA_SMALL_SECTORED;
            post_add <= 1'b0;
            held_index <= SEA_ZERO_WORD;
            mem_addr_q <= SEA_ZERO_WORD;
            ea_valid_q <= 1'b0;
            ea_q <= SEA_ZERO_WORD;
            func_q <= 4'h0;
            ext_valid_q <= 1'b0;
            ext_q <= 9'h000;
            levels_q <= 4'h0;
        end else begin
            state <= next_state;
            cur_mode <= next_cur_mode;
            post_add <= next_post_add;
            held_index <= next_held_index;
            mem_addr_q <= next_mem_addr_q;
            ea_valid_q <= next_ea_valid_q;
            ea_q <= next_ea_q;
            func_q <= next_func_q;
            ext_valid_q <= next_ext_valid_q;
            ext_q <= next_ext_q;
            levels_q <= next_levels_q;
        end
    end

    assign busy = (state != SEA_ST_IDLE);
    assign mem_req = (state == SEA_ST_FETCH);
    assign mem_addr = mem_addr_q;
    assign ea_valid = ea_valid_q;
    assign ea = ea_q;
    assign ea_function = func_q;
    assign ext_valid = ext_valid_q;
    assign ext_field = ext_q;
    assign indirect_levels = levels_q;
endmodule // sea_effective_address
`default_nettype wire

// ### sea_ea_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sea_ea_assertions
    import sea_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] next_instr_count,
    input wire logic [15:0] index_reg,
    input wire sea_mode_t mode,
    input wire logic busy,
    // memory
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // result
    input wire logic ea_valid,
    input wire logic [15:0] ea,
    input wire logic ext_valid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic [15:0] msk = mode == SEA_SMALL_SECTORED ? 16'h3FFF :
        mode == SEA_RELATIVE_FULL ? 16'hFFFF : 16'h7FFF;
    sequence s_take;
        start && !busy;
    endsequence
    AST_BASIC: assert property (s_take ##0 (instr[15:14] == 2'h0 && !instr[9])
        |=> ea_valid && ea == {7'h00, $past(instr[8:0])})
        else $error("basic address wrong");
    AST_INDEX: assert property (s_take ##0 (instr[15:14] == 2'h1 && !instr[9])
        |=> ea == (({7'h00, $past(instr[8:0])} + $past(index_reg))
        & $past(msk))) else $error("indexed address wrong");
    AST_SECTOR: assert property (s_take ##0 (instr[15:14] == 2'h0 && instr[9]
        && !mode[1]) |=> ea == ({$past(next_instr_count[15:9]),
        $past(instr[8:0])} & $past(msk))) else $error("sector wrong");
    AST_REL: assert property (s_take ##0 (instr[15:14] == 2'h0 && instr[9]
        && mode[1] && instr[8:7] != 2'h3 && instr[8:4] != 5'h10)
        |=> ea_valid && ea == (($past(next_instr_count) + {{7{$past(instr[8])}},
        $past(instr[8:0])}) & $past(msk))) else $error("relative wrong");
    AST_EXT: assert property (s_take ##0 (!instr[15] && instr[9] && mode[1]
        && instr[8:7] == 2'h3) |=> ext_valid && !ea_valid)
        else $error("code not reported");
    AST_FETCH: assert property (s_take ##0 (instr[15:14] == 2'h2 && !instr[9])
        |=> busy && mem_req && mem_addr == {7'h00, $past(instr[8:0])})
        else $error("first fetch wrong");
    AST_HOLD: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr)) else $error("fetch not held");
    AST_CHAIN: assert property (mem_req && mem_ack && mem_rdata[15]
        && mode != SEA_RELATIVE_FULL |=> mem_req
        && mem_addr == ($past(mem_rdata) & $past(msk)))
        else $error("chain wrong");
    AST_LAST: assert property (mem_req && mem_ack && (!mem_rdata[15]
        || mode == SEA_RELATIVE_FULL) |=> ea_valid && !mem_req)
        else $error("chain not ended");
endmodule // sea_ea_assertions
bind sea_effective_address sea_ea_assertions i_sea_ea_assertions(.*);
`default_nettype wire

// ### sea_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sea_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // memory port
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic slow,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [16];
    logic [1:0] wait_cnt;
    // data toggles outside an answer so stale words never look valid
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'hA5A5;
            wait_cnt <= 2'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= {slow, 1'b0}) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[3:0]];
            wait_cnt <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt <= wait_cnt + {1'b0, mem_req && !mem_ack};
        end
    end
endmodule // sea_mem_model
`default_nettype wire

// ### sea_effective_address_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sea_effective_address_bench;
    import sea_pkg::*;
    logic core_clk, rst_n, start, busy, mem_req, mem_ack, slow;
    logic ea_valid, ext_valid;
    logic [15:0] instr, next_instr_count, index_reg, mem_addr, mem_rdata, ea;
    logic [3:0] ea_function, indirect_levels;
    logic [8:0] ext_field;
    sea_mode_t mode;
    int bad_count, total_checks, cycles;
    sea_effective_address i_sea_effective_address(.*);
    sea_mem_model i_sea_mem_model(.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input sea_mode_t m, input logic [15:0] w, p, x);
        int n;
        @(negedge core_clk);
        mode = m;
        instr = w;
        next_instr_count = p;
        index_reg = x;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        n = 0;
        while (ea_valid !== 1'b1 && ext_valid !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic t_direct();
        run(SEA_SMALL_SECTORED, 16'h54FF, 16'h1234, 16'h7F00);
        chk(ea, 16'h3FFF);
        chk({12'h000, ea_function}, 16'h0005);
        run(SEA_RELATIVE_FULL, 16'h01FF, 16'hFFFF, 16'h0000);
        chk(ea, 16'h01FF);
        run(SEA_LARGE_SECTORED, 16'h02AB, 16'hFE34, 16'h0000);
        chk(ea, 16'h7EAB);
        run(SEA_SMALL_SECTORED, 16'h02AB, 16'hFE34, 16'h0000);
        chk(ea, 16'h3EAB);
        run(SEA_LARGE_SECTORED, 16'h03C5, 16'h0000, 16'h0000);
        chk({15'h0000, ea_valid}, 16'h0001);
        chk(ea, 16'h01C5);
    endtask
    task automatic t_rel();
        run(SEA_RELATIVE_LARGE, 16'h0310, 16'h0100, 16'h0000);
        chk(ea, 16'h0010);
        run(SEA_RELATIVE_FULL, 16'h02FF, 16'hFFF0, 16'h0000);
        chk(ea, 16'h00EF);
        run(SEA_RELATIVE_FULL, 16'h03C5, 16'h0000, 16'h0000);
        chk({15'h0000, ext_valid}, 16'h0001);
        chk({7'h00, ext_field}, 16'h01C5);
        run(SEA_RELATIVE_LARGE, 16'h030F, 16'h0000, 16'h0000);
        chk({15'h0000, ext_valid}, 16'h0001);
    endtask
    task automatic t_indirect();
        i_sea_mem_model.mem[2] = 16'h8005;
        i_sea_mem_model.mem[5] = 16'h4ABC;
        i_sea_mem_model.mem[3] = 16'h1000;
        i_sea_mem_model.mem[4] = 16'hF000;
        run(SEA_SMALL_SECTORED, 16'hC010, 16'h0000, 16'h0002);
        chk(ea, 16'h0ABC);
        chk({12'h000, indirect_levels}, 16'h0002);
        run(SEA_LARGE_SECTORED, 16'h8002, 16'h0000, 16'h0000);
        chk(ea, 16'h4ABC);
        slow = 1'b1;
        run(SEA_LARGE_SECTORED, 16'hC203, 16'h0200, 16'h0010);
        chk(ea, 16'h1010);
        run(SEA_RELATIVE_FULL, 16'h8204, 16'h0000, 16'h0000);
        chk(ea, 16'hF000);
        chk({12'h000, indirect_levels}, 16'h0001);
    endtask
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        instr = 16'h0000;
        next_instr_count = 16'h0000;
        index_reg = 16'h0000;
        mode = SEA_SMALL_SECTORED;
        slow = 1'b0;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        t_direct();
        t_rel();
        t_indirect();
        conclude();
    end
endmodule // sea_effective_address_bench
`default_nettype wire
